// File: src/quad_uart_irq_ready_pins.sv
// Operation
// - Strobe mode: channel A irq driven when control bit 3 or override set, else floated.
// - Strobe mode: channels B-D irq driven per own control bit 3.
// - Read/write-line mode: channel A pin is shared active-low open-drain irq.
// - Read/write-line mode: channels B-D irq pins held at zero.
// - Strobe mode: override high enables all four irq outputs.
// - Strobe mode: with override low, control bit 3 must be set to drive pins.
// - Transmit-ready summary is AND of four active-low channel signals.
// - Receive-ready summary is AND of four active-low channel signals.
// - Serial outputs high in reset and while idle.
// - Each channel has active-low request-to-send output, general-purpose.
// - Each channel takes active-low clear-to-send input; unused tied high.
`timescale 1ns/1ps
`default_nettype none

module quad_uart_irq_ready_pins
  import irq_pins_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic                 busStyleSel,
  input  wire logic                 irqOutputOverride,
  input  wire logic [4*MODEM_CTRL_WIDTH-1:0] modemControlReg,
  input  wire logic [CHANNELS-1:0]  irqPending,
  input  wire logic [CHANNELS-1:0]  chanTxReady_n,
  input  wire logic [CHANNELS-1:0]  chanRxReady_n,
  input  wire logic [CHANNELS-1:0]  txActive,
  input  wire logic [CHANNELS-1:0]  txBit,
  input  wire logic [CHANNELS-1:0]  rtsCtrl,
  input  wire logic [CHANNELS-1:0]  serialInChan,
  input  wire logic [CHANNELS-1:0]  clearToSend_n,
  output var  logic [CHANNELS-1:0]  irqOut,
  output var  logic [CHANNELS-1:0]  irqOe_b,
  output var  logic                 txReadySummary_n,
  output var  logic                 rxReadySummary_n,
  output var  logic [CHANNELS-1:0]  serialOutChan,
  output var  logic [CHANNELS-1:0]  requestToSend_n,
  output var  logic [CHANNELS-1:0]  serialInSync,
  output var  logic [CHANNELS-1:0]  clearToSendSync
);

  // ****************************************************************
  // Pin input synchronisers.
  // ****************************************************************
  logic              styleMeta_reg;
  logic              styleSync_reg;
  logic              ovrMeta_reg;
  logic              ovrSync_reg;
  logic [CHANNELS-1:0] rxMeta_reg;
  logic [CHANNELS-1:0] ctsMeta_reg;

  // Each pin passes two flops before any logic reads it, so a change that
  // lands near a clock edge cannot spread an unsettled level into the core.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      styleMeta_reg <= BUS_STROBE;
      styleSync_reg <= BUS_STROBE;
    end
    else
    begin
      styleMeta_reg <= busStyleSel;
      styleSync_reg <= styleMeta_reg;
    end
  end

  // Override pin; it resets inactive so no interrupt pin is driven early.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ovrMeta_reg <= 1'b0;
      ovrSync_reg <= 1'b0;
    end
    else
    begin
      ovrMeta_reg <= irqOutputOverride;
      ovrSync_reg <= ovrMeta_reg;
    end
  end

  // Receive lines reset to the idle level so no false start is seen.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rxMeta_reg   <= {CHANNELS{LINE_IDLE}};
      serialInSync <= {CHANNELS{LINE_IDLE}};
    end
    else
    begin
      rxMeta_reg   <= serialInChan;
      serialInSync <= rxMeta_reg;
    end
  end

  // Clear-to-send inputs reset to the inactive high level.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ctsMeta_reg     <= {CHANNELS{1'b1}};
      clearToSendSync <= {CHANNELS{1'b1}};
    end
    else
    begin
      ctsMeta_reg     <= clearToSend_n;
      clearToSendSync <= ctsMeta_reg;
    end
  end

  // ****************************************************************
  // Per-channel interrupt pins.
  // ****************************************************************
  logic                     strobeMode;
  logic                     overrideEff;
  logic                     devIrq;
  wire logic [CHANNELS-1:0] chanIrqEn;

  // Picks the interrupt-enable bit out of one channel's control byte.
  // Each channel owns one byte of the packed control word.
  function automatic logic ctrl_irq_bit(
    input logic [4*MODEM_CTRL_WIDTH-1:0] ctrlWord,
    input int                            chan
  );
    return ctrlWord[chan*MODEM_CTRL_WIDTH+MODEM_CTRL_IRQ_EN];
  endfunction : ctrl_irq_bit

  // Override is ignored in read/write-line mode.
  assign strobeMode  = (styleSync_reg == BUS_STROBE);
  assign overrideEff = strobeMode & ovrSync_reg;
  assign devIrq      = |irqPending;

  // One registered pin per channel; channel A also carries the shared
  // open-drain interrupt when the read/write-line style is selected.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : gIrq
      // The channel's own control byte gates its pin in strobe style.
      assign chanIrqEn[ch] = ctrl_irq_bit(modemControlReg, ch);

      irq_chan_pin uPin (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .isChanA    (ch == CHAN_A),
        .strobeMode (strobeMode),
        .override   (overrideEff),
        .ctrlIrqEn  (chanIrqEn[ch]),
        .pending    (irqPending[ch]),
        .devIrq     (devIrq),
        .pinOut     (irqOut[ch]),
        .pinOe_b    (irqOe_b[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // Ready summaries.
  // ****************************************************************

  // Transmit summary is low while any channel reports itself ready.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      txReadySummary_n <= NOT_READY_N;
    end
    else
    begin
      txReadySummary_n <= &chanTxReady_n;
    end
  end

  // Receive summary is low while any channel reports itself ready.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rxReadySummary_n <= NOT_READY_N;
    end
    else
    begin
      rxReadySummary_n <= &chanRxReady_n;
    end
  end

  // ****************************************************************
  // Serial and handshake outputs.
  // ****************************************************************

  // The transmit line shows the data bit only while a channel sends.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      serialOutChan <= {CHANNELS{LINE_IDLE}};
    end
    else
    begin
      serialOutChan <= txBit | ~txActive;
    end
  end

  // Request-to-send is low while the core asserts it; reset leaves it off.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      requestToSend_n <= {CHANNELS{RTS_RESET_N}};
    end
    else
    begin
      requestToSend_n <= ~rtsCtrl;
    end
  end

endmodule : quad_uart_irq_ready_pins

`default_nettype wire

// File: src/irq_pins_pkg.sv
`default_nettype none

package irq_pins_pkg;

  // ****************************************************************
  // Channel and interface constants.
  // ****************************************************************
  localparam int unsigned CHANNELS          = 4;
  localparam int unsigned CHAN_A            = 0;
  localparam int unsigned MODEM_CTRL_IRQ_EN = 3;
  localparam int unsigned MODEM_CTRL_WIDTH  = 8;
  localparam logic [7:0]  MODEM_CTRL_RESET  = 8'h00;
  localparam logic        LINE_IDLE         = 1'b1;
  localparam logic        NOT_READY_N       = 1'b1;
  localparam logic        RTS_RESET_N       = 1'b1;

  // Bus styles chosen by the bus-style select input.
  typedef enum logic [0:0] {
    BUS_RWLINE = 1'b0,
    BUS_STROBE = 1'b1
  } bus_style_t;

endpackage : irq_pins_pkg

`default_nettype wire

// File: src/irq_chan_pin.sv
`timescale 1ns/1ps
`default_nettype none

// ******************************************************************
// One channel interrupt pin: value and output enable, registered.
// ******************************************************************
module irq_chan_pin
  import irq_pins_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic isChanA,
  input  wire logic strobeMode,
  input  wire logic override,
  input  wire logic ctrlIrqEn,
  input  wire logic pending,
  input  wire logic devIrq,
  output var  logic pinOut,
  output var  logic pinOe_b
);

  logic driveEn;
  logic pinNext;
  logic oeNext;

  // Select level and enable per bus style.
  always_comb
  begin
    driveEn = override | ctrlIrqEn;
    if (strobeMode)
    begin
      pinNext = pending;
      oeNext  = ~driveEn;
    end
    else if (isChanA)
    begin
      pinNext = 1'b0;
      oeNext  = ~devIrq;                       // Pull low only.
    end
    else
    begin
      pinNext = 1'b0;
      oeNext  = 1'b0;
    end
  end

  // Pins are released after reset.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pinOut  <= 1'b0;
      pinOe_b <= 1'b1;
    end
    else
    begin
      pinOut  <= pinNext;
      pinOe_b <= oeNext;
    end
  end

endmodule : irq_chan_pin

`default_nettype wire

// File: bench/quad_uart_irq_ready_pins_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Pin behaviour checks.
// ****************************************************************
module quad_uart_irq_ready_pins_asserts (
  input wire logic        core_clk, rst_b, busStyleSel, irqOutputOverride,
  input wire logic [31:0] modemControlReg,
  input wire logic [3:0]  irqPending, chanTxReady_n, chanRxReady_n, txBit,
  input wire logic [3:0]  txActive, rtsCtrl, irqOut, irqOe_b, serialOutChan,
  input wire logic [3:0]  requestToSend_n, serialInChan, clearToSend_n,
  input wire logic [3:0]  serialInSync, clearToSendSync,
  input wire logic        txReadySummary_n, rxReadySummary_n
);
  logic [4:0] sty, ovr;
  logic [2:0] age;
  wire  [3:0] en = {modemControlReg[27], modemControlReg[19],
                    modemControlReg[11], modemControlReg[3]};
  // Pin history lets a check wait out the two-flop synchronisers.
  always_ff @(posedge core_clk)
  begin
    sty <= {sty[3:0], busStyleSel};
    ovr <= {ovr[3:0], irqOutputOverride};
    age <= !rst_b ? 3'h0 : age + {2'h0, age != 3'h5};
  end
  wire ok = age == 3'h5;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence strobe_s; ok && &sty; endsequence
  sequence rwline_s; ok && ~|sty; endsequence
  strobe_enable_a: assert property (strobe_s ##0 ~|ovr |->
    irqOe_b == ~$past(en)) else $error("irq enable wrong");
  override_on_a: assert property (strobe_s ##0 &ovr |->
    irqOe_b == 4'h0) else $error("override not driving");
  strobe_level_a: assert property (strobe_s |->
    irqOut == $past(irqPending)) else $error("irq level wrong");
  shared_irq_a: assert property (rwline_s |-> !irqOut[0] &&
    irqOe_b[0] == ~|$past(irqPending)) else $error("shared irq wrong");
  unused_pins_a: assert property (rwline_s |-> irqOut[3:1] == 3'h0 &&
    irqOe_b[3:1] == 3'h0) else $error("unused pins not low");
  ready_sum_a: assert property (ok |->
    {txReadySummary_n, rxReadySummary_n} == {&$past(chanTxReady_n),
    &$past(chanRxReady_n)}) else $error("ready summary wrong");
  serial_idle_a: assert property (ok |-> serialOutChan ==
    ($past(txBit) | ~$past(txActive))) else $error("tx line wrong");
  rts_follow_a: assert property (ok |->
    requestToSend_n == ~$past(rtsCtrl)) else $error("rts wrong");
  sync_pins_a: assert property (ok |->
    {serialInSync, clearToSendSync} == {$past(serialInChan, 2),
    $past(clearToSend_n, 2)}) else $error("synced pins wrong");
endmodule : quad_uart_irq_ready_pins_asserts
`default_nettype wire

// File: bench/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Remote serial peer: idles high, or echoes the transmit lines.
module serial_peer (
  input  wire logic       loop,
  input  wire logic [3:0] txLine,
  output var  logic [3:0] rxLine,
  output var  logic [3:0] ctsLine_n
);
  assign rxLine = loop ? txLine : 4'hf;
  assign ctsLine_n = loop ? 4'ha : 4'hf;
endmodule : serial_peer
`default_nettype wire

// File: bench/quad_uart_irq_ready_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module quad_uart_irq_ready_pins_tb;
  logic core_clk = 1'h0, rst_b = 1'h0, busStyleSel = 1'h1, loop = 1'h0;
  logic irqOutputOverride = 1'h0, txReadySummary_n, rxReadySummary_n;
  logic [31:0] modemControlReg = 32'h0;
  logic [3:0] irqPending = 4'h0, chanTxReady_n = 4'hf, chanRxReady_n = 4'hf;
  logic [3:0] txActive = 4'h0, txBit = 4'h0, rtsCtrl = 4'h0, serialInChan;
  logic [3:0] clearToSend_n, irqOut, irqOe_b, serialOutChan, requestToSend_n;
  logic [3:0] serialInSync, clearToSendSync;
  int fail_count = 0, comparisons = 0;
  quad_uart_irq_ready_pins DUT (.*);
  serial_peer peer (.loop, .txLine(serialOutChan), .rxLine(serialInChan),
    .ctsLine_n(clearToSend_n));
  initial forever #10 core_clk = ~core_clk;
  task step(input int n); repeat (n) @(negedge core_clk); endtask : step
  task chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t saw %h want %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // Each channel enable bit drives only its own pin.
  task t_strobe;
    irqPending = 4'ha;
    for (int c = 0; c < 4; c++)
    begin
      modemControlReg = 32'h8 << (8 * c);
      step(2);
      chk(irqOe_b, ~(4'h1 << c));
      chk(irqOut & (4'h1 << c), 4'ha & (4'h1 << c));
    end
    modemControlReg = 32'h0;
    irqOutputOverride = 1'h1;
    step(8);
    chk(irqOe_b, 4'h0);
    irqOutputOverride = 1'h0;
    step(5);
    chk(irqOe_b, 4'hf);
    $display("strobe test done");
  endtask : t_strobe
  // Read/write-line mode ignores the enable bits entirely.
  task t_rwline;
    busStyleSel = 1'h0;
    irqOutputOverride = 1'h0;
    irqPending = 4'h0;
    modemControlReg = 32'hffffffff;
    step(5);
    chk(irqOe_b, 4'h1);
    irqPending = 4'h8;
    step(2);
    chk(irqOe_b, 4'h0);
    chk(irqOut, 4'h0);
    busStyleSel = 1'h1;
    step(5);
    $display("rw-line test done");
  endtask : t_rwline
  // One channel at a time ready, then none ready.
  task t_ready;
    for (int i = 0; i < 5; i++)
    begin
      chanTxReady_n = 4'hf ^ (4'h1 << i);
      chanRxReady_n = 4'hf ^ (4'h8 >> i);
      step(2);
      chk({txReadySummary_n, rxReadySummary_n}, {2{i == 4}});
    end
    $display("ready test done");
  endtask : t_ready
  // Idle lines, request-to-send, then echoed data through the peer.
  task t_serial;
    txBit = 4'h5;
    rtsCtrl = 4'h6;
    step(4);
    chk(serialOutChan, 4'hf);
    chk(requestToSend_n, 4'h9);
    chk(serialInSync, 4'hf);
    txActive = 4'hf;
    loop = 1'h1;
    step(6);
    chk(serialInSync, 4'h5);
    chk(clearToSendSync, 4'ha);
    loop = 1'h0;
    $display("serial test done");
  endtask : t_serial
  // A reset in mid-run returns the irq, serial, request-to-send and ready-summary outputs to their reset levels.
  task t_reset;
    modemControlReg = 32'h08080808;
    irqPending = 4'hf;
    chanTxReady_n = 4'h0;
    chanRxReady_n = 4'h0;
    txBit = 4'h0;
    rtsCtrl = 4'hf;
    step(2);
    chk(irqOe_b | serialOutChan | requestToSend_n, 4'h0);
    rst_b = 1'h0;
    step(2);
    chk(irqOe_b, 4'hf);
    chk(irqOut, 4'h0);
    chk(serialOutChan & requestToSend_n, 4'hf);
    chk({txReadySummary_n, rxReadySummary_n}, 4'h3);
    rst_b = 1'h1;
    step(2);
    chk(irqOe_b | serialOutChan | requestToSend_n, 4'h0);
    chk({txReadySummary_n, rxReadySummary_n}, 4'h0);
    $display("reset test done");
  endtask : t_reset
  initial
  begin
    step(12);
    chk(irqOe_b, 4'hf);
    chk(serialOutChan & requestToSend_n, 4'hf);
    rst_b = 1'h1;
    step(6);
    t_strobe();
    t_rwline();
    t_ready();
    t_serial();
    t_reset();
    finish_test();
  end
  initial
  begin
    repeat (1000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end
endmodule : quad_uart_irq_ready_pins_tb
bind quad_uart_irq_ready_pins quad_uart_irq_ready_pins_asserts chk_i (.*);
`default_nettype wire
